// File: core/dacz_consts.svh
// Contract
// - channel zero flag goes active after 8192 consecutive zero frames
// - active zero flag drops at once when a nonzero sample arrives
// - timing-reset bit 0 forces both flags active; clear 2-3 frames after 1
// - combine mode: both flags active only when both channels hit 8192
// - detection disabled holds both zero flag pins low
// - polarity bit inverts both zero flag pins
// - soft mute ramps level down to mute, one step per step time
// - mute release ramps back up to programmed volume at same rate
// - mute released mid-ramp turns the ramp around at the same rate
// - power-down pin low returns every register to its default
// - power-down pin low: converter down, outputs float, flags low
// - after power-down, wait for both clocks; start on frame rising edge
// - timing-reset bit 0: converter down, outputs mid-supply, registers kept
// - internal timing reset asserts 3-4 frames after 0, releases 2-3 after 1
// - serial port only in serial mode; host pulses power-down on change
// - transfer is chip address 01, write 1, 5-bit address, 8 data, MSB first
// - device samples on rising control clock; host changes on falling
// - received word is committed only on the rising chip select edge
// - writes ignored while power-down pin low or master clock absent
// - auto clock setting ignores speed select; otherwise speed select rules
// - one ramp step lasts 4, 8 or 16 frames by speed mode
// - polarity 0: flag high on detection; polarity 1: flag low on detection
`ifndef DACZ_CONSTS_SVH
`define DACZ_CONSTS_SVH
`define DACZ_CLK_MHZ 20
`define DACZ_FRAME_TIMEOUT_US 200
`define DACZ_FRAME_TIMEOUT_CYC (`DACZ_FRAME_TIMEOUT_US * `DACZ_CLK_MHZ)
`define DACZ_ZERO_FRAMES 8192
`define DACZ_RESET_ASSERT_EDGES 3'h4
`define DACZ_RESET_RELEASE_EDGES 3'h3
`define DACZ_STEP_NORMAL 5'h04
`define DACZ_STEP_DOUBLE 5'h08
`define DACZ_STEP_QUAD 5'h10
`define DACZ_FRAME_BITS 5'h10
`define DACZ_CHIP_ADDR 2'h1
`define DACZ_WRITE_BIT 1'h1
`define DACZ_PIN_IDLE 5'h10
`define DACZ_ADDR_MAIN 5'h00
`define DACZ_ADDR_FILTER 5'h01
`define DACZ_ADDR_POLARITY 5'h02
`define DACZ_ADDR_LEFT_VOL 5'h03
`define DACZ_ADDR_RIGHT_VOL 5'h04
`define DACZ_RST_MAIN 8'h8B
`define DACZ_RST_FILTER 8'h02
`define DACZ_RST_POLARITY 8'h00
`define DACZ_RST_VOLUME 8'hFF
`define DACZ_MASK_MAIN 8'h9F
`define DACZ_MASK_FILTER 8'hFF
`define DACZ_MASK_POLARITY 8'h1C
`define DACZ_BIT_AUTO_CLOCK_SETTING 7
`define DACZ_BIT_PW 1
`define DACZ_BIT_TIMING_RESET_BIT_N 0
`define DACZ_BIT_ZERO_DETECT_ENABLE 7
`define DACZ_BIT_ZERO_DETECT_COMBINE_MODE 6
`define DACZ_BIT_SLOW 5
`define DACZ_BIT_SOFT_MUTE_BIT 0
`define DACZ_BIT_LEFT_OUTPUT_INVERT 4
`define DACZ_BIT_RIGHT_OUTPUT_INVERT 3
`define DACZ_BIT_ZERO_FLAG_POLARITY 2
`endif

// File: core/dacz_pkg.sv
package dacz_pkg;
    typedef enum logic [1:0] {DACZ_NORMAL, DACZ_DOUBLE, DACZ_QUAD}
        dacz_speed_t;
    typedef enum logic [1:0] {DACZ_PWR_DOWN, DACZ_PWR_WAIT, DACZ_PWR_RUN}
        dacz_power_t;
endpackage

// File: core/dacz_ramp.sv
`timescale 1ns/1ps
`default_nettype none
module dacz_ramp
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic frame_tick,
    input wire logic jump,
    input wire logic [4:0] step_frames,
    input wire logic [7:0] target,
    output logic [7:0] level
);
    logic [4:0] frames;
    logic [4:0] next_frames;

    assign next_frames = frames + 5'h01;

    // count frames toward one step; a settled ramp keeps the counter clear
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            frames <= 5'h00;
        else if (jump || level == target)
            frames <= 5'h00;
        else if (frame_tick)
            frames <= (next_frames >= step_frames) ? 5'h00 : next_frames;
    end

    // one code per step toward target, so a flip of target mid-way simply
    // turns the ramp round at the same rate
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            level <= 8'hFF;
        else if (jump)
            level <= target;
        else if (frame_tick && level != target && next_frames >= step_frames)
        begin
            if (level > target)
                level <= level - 8'h01;
            else
                level <= level + 8'h01;
        end
    end
endmodule
`default_nettype wire

// File: core/dacz_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "dacz_consts.svh"
module dacz_control
#(
    parameter int ZERO_FRAMES = `DACZ_ZERO_FRAMES,
    parameter int FRAME_TIMEOUT = `DACZ_FRAME_TIMEOUT_CYC
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic control_clock,
    input wire logic control_select_n,
    input wire logic control_data_in,
    input wire logic power_down_pin_n,
    input wire logic parallel_select,
    input wire logic master_clock_present,
    input wire logic frame_clock,
    input wire logic sample_strobe,
    input wire logic left_sample_zero,
    input wire logic right_sample_zero,
    input wire logic [1:0] detected_speed,
    output logic left_zero_flag,
    output logic right_zero_flag,
    output logic analog_float,
    output logic converter_running,
    output logic output_midsupply,
    output logic timing_reset_active,
    output logic [1:0] speed_mode,
    output logic [2:0] audio_format_select,
    output logic [1:0] deemphasis_select,
    output logic slow_rolloff,
    output logic left_output_invert,
    output logic right_output_invert,
    output logic [7:0] left_gain,
    output logic [7:0] right_gain
);
    localparam int ZW = $clog2(ZERO_FRAMES + 1);
    localparam int TW = $clog2(FRAME_TIMEOUT + 1);
    localparam int PIN_PDN = 0;
    localparam int PIN_PS = 1;
    localparam int PIN_MCLK = 2;
    localparam int PIN_FRAME_CLOCK = 3;
    localparam int PIN_CSN = 4;

    // ---------------- link domain: serial control port ----------------
    logic link_open;
    logic [4:0] link_bits;
    logic [15:0] link_word;

    // chip select high closes the frame at once; the control clock is
    // stopped between frames so nothing else could end it
    always_ff @(posedge control_clock or posedge control_select_n)
    begin
        if (control_select_n)
            link_open <= 1'b0;
        else
            link_open <= 1'b1;
    end

    // bit counter restarts on the first edge of each frame, saturates past 16
    always_ff @(posedge control_clock or negedge rst_n)
    begin
        if (!rst_n)
            link_bits <= 5'h00;
        else if (!link_open)
            link_bits <= 5'h01;
        else if (link_bits <= `DACZ_FRAME_BITS)
            link_bits <= link_bits + 5'h01;
    end

    // msb first shift on the rising control clock edge
    always_ff @(posedge control_clock or negedge rst_n)
    begin
        if (!rst_n)
            link_word <= 16'h0000;
        else
            link_word <= {link_word[14:0], control_data_in};
    end

    // ---------------- pin synchronisers ----------------
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic [4:0] pin_s3;
    logic [4:0] pin_f;
    logic [4:0] pin_prev;

    // three stages; a level counts only once stages two and three agree
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1 <= `DACZ_PIN_IDLE;
            pin_s2 <= `DACZ_PIN_IDLE;
            pin_s3 <= `DACZ_PIN_IDLE;
            pin_f <= `DACZ_PIN_IDLE;
            pin_prev <= `DACZ_PIN_IDLE;
        end
        else
        begin
            pin_s1 <= {control_select_n, frame_clock, master_clock_present,
                       parallel_select, power_down_pin_n};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_f <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));
            pin_prev <= pin_f;
        end
    end

    logic pdn_n;
    logic mclk_ok;
    logic frame_tick;
    logic frame_edge;
    logic select_rise;

    assign pdn_n = pin_f[PIN_PDN];
    assign mclk_ok = pin_f[PIN_MCLK];
    assign frame_tick = pin_f[PIN_FRAME_CLOCK] && !pin_prev[PIN_FRAME_CLOCK];
    assign frame_edge = pin_f[PIN_FRAME_CLOCK] != pin_prev[PIN_FRAME_CLOCK];
    assign select_rise = pin_f[PIN_CSN] && !pin_prev[PIN_CSN];

    // ---------------- commit of a received word ----------------
    logic commit;
    logic [4:0] commit_addr;
    logic [7:0] commit_data;

    // link_word is read only after chip select has risen and crossed three
    // stages, so the stopped control clock leaves it frozen: no tearing
    assign commit = select_rise
        && link_bits == `DACZ_FRAME_BITS
        && link_word[15:14] == `DACZ_CHIP_ADDR
        && link_word[13] == `DACZ_WRITE_BIT
        && !pin_f[PIN_PS]
        && pdn_n && mclk_ok;
    assign commit_addr = link_word[12:8];
    assign commit_data = link_word[7:0];

    // ---------------- register file ----------------
    logic [7:0] main_control;
    logic [7:0] filter_and_mute_control;
    logic [7:0] polarity_control;
    logic [7:0] left_volume;
    logic [7:0] right_volume;

    // power-down pin restores defaults; unused addresses drop silently;
    // neither converter power nor timing reset blocks a write
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            main_control <= `DACZ_RST_MAIN;
            filter_and_mute_control <= `DACZ_RST_FILTER;
            polarity_control <= `DACZ_RST_POLARITY;
            left_volume <= `DACZ_RST_VOLUME;
            right_volume <= `DACZ_RST_VOLUME;
        end
        else if (!pdn_n)
        begin
            main_control <= `DACZ_RST_MAIN;
            filter_and_mute_control <= `DACZ_RST_FILTER;
            polarity_control <= `DACZ_RST_POLARITY;
            left_volume <= `DACZ_RST_VOLUME;
            right_volume <= `DACZ_RST_VOLUME;
        end
        else if (commit)
        begin
            case (commit_addr)
                `DACZ_ADDR_MAIN:
                    main_control <= commit_data & `DACZ_MASK_MAIN;
                `DACZ_ADDR_FILTER:
                    filter_and_mute_control <= commit_data & `DACZ_MASK_FILTER;
                `DACZ_ADDR_POLARITY:
                    polarity_control <= commit_data & `DACZ_MASK_POLARITY;
                `DACZ_ADDR_LEFT_VOL:
                    left_volume <= commit_data;
                `DACZ_ADDR_RIGHT_VOL:
                    right_volume <= commit_data;
                default:
                    main_control <= main_control;
            endcase
        end
    end

    logic timing_reset_bit_n;
    logic converter_power_bit;
    logic auto_clock_setting;
    logic zero_detect_enable;
    logic zero_detect_combine_mode;
    logic zero_flag_polarity;
    logic soft_mute_bit;

    assign timing_reset_bit_n = main_control[`DACZ_BIT_TIMING_RESET_BIT_N];
    assign converter_power_bit = main_control[`DACZ_BIT_PW];
    assign auto_clock_setting = main_control[`DACZ_BIT_AUTO_CLOCK_SETTING];
    assign zero_detect_enable = filter_and_mute_control[`DACZ_BIT_ZERO_DETECT_ENABLE];
    assign zero_detect_combine_mode = filter_and_mute_control[`DACZ_BIT_ZERO_DETECT_COMBINE_MODE];
    assign zero_flag_polarity = polarity_control[`DACZ_BIT_ZERO_FLAG_POLARITY];
    assign soft_mute_bit = filter_and_mute_control[`DACZ_BIT_SOFT_MUTE_BIT];

    // plain configuration fields straight from register flops
    assign audio_format_select = main_control[4:2];
    assign deemphasis_select = filter_and_mute_control[2:1];
    assign slow_rolloff = filter_and_mute_control[`DACZ_BIT_SLOW];
    assign left_output_invert = polarity_control[`DACZ_BIT_LEFT_OUTPUT_INVERT];
    assign right_output_invert = polarity_control[`DACZ_BIT_RIGHT_OUTPUT_INVERT];

    // ---------------- speed mode ----------------
    function automatic dacz_pkg::dacz_speed_t to_speed(input logic [1:0] code);
        unique case (code)
            2'h1: to_speed = dacz_pkg::DACZ_DOUBLE;
            2'h2: to_speed = dacz_pkg::DACZ_QUAD;
            default: to_speed = dacz_pkg::DACZ_NORMAL;
        endcase
    endfunction

    function automatic logic [4:0] step_for(input dacz_pkg::dacz_speed_t sp);
        unique case (sp)
            dacz_pkg::DACZ_NORMAL: step_for = `DACZ_STEP_NORMAL;
            dacz_pkg::DACZ_DOUBLE: step_for = `DACZ_STEP_DOUBLE;
            dacz_pkg::DACZ_QUAD: step_for = `DACZ_STEP_QUAD;
            default: step_for = `DACZ_STEP_NORMAL;
        endcase
    endfunction

    dacz_pkg::dacz_speed_t speed;
    logic [4:0] step_frames;

    // auto setting takes the detector's verdict and ignores the field
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            speed <= dacz_pkg::DACZ_NORMAL;
        else if (auto_clock_setting)
            speed <= to_speed(detected_speed);
        else
            speed <= to_speed(filter_and_mute_control[4:3]);
    end

    assign speed_mode = speed;
    assign step_frames = step_for(speed);

    // ---------------- frame clock presence and power state ----------------
    logic [TW-1:0] frame_idle;
    logic frame_present;

    // an edge of either sense restarts the watchdog
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            frame_idle <= TW'(FRAME_TIMEOUT);
        else if (frame_edge)
            frame_idle <= '0;
        else if (frame_idle != TW'(FRAME_TIMEOUT))
            frame_idle <= frame_idle + TW'(1);
    end

    assign frame_present = frame_idle != TW'(FRAME_TIMEOUT);

    dacz_pkg::dacz_power_t power_state;

    // stays down until both clocks run, then starts on a frame rising edge
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            power_state <= dacz_pkg::DACZ_PWR_DOWN;
        else if (!pdn_n)
            power_state <= dacz_pkg::DACZ_PWR_DOWN;
        else
        begin
            unique case (power_state)
                dacz_pkg::DACZ_PWR_DOWN:
                    power_state <= dacz_pkg::DACZ_PWR_WAIT;
                dacz_pkg::DACZ_PWR_WAIT:
                    if (mclk_ok && frame_present && frame_tick)
                        power_state <= dacz_pkg::DACZ_PWR_RUN;
                dacz_pkg::DACZ_PWR_RUN:
                    if (!mclk_ok || !frame_present)
                        power_state <= dacz_pkg::DACZ_PWR_WAIT;
                default:
                    power_state <= dacz_pkg::DACZ_PWR_DOWN;
            endcase
        end
    end

    // ---------------- internal timing reset ----------------
    logic internal_run;
    logic [2:0] reset_edges;
    logic [2:0] next_reset_edges;

    assign next_reset_edges = reset_edges + 3'h1;

    // the k-th frame rising edge after a write lies k-1 to k frames later
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            internal_run <= 1'b1;
            reset_edges <= 3'h0;
        end
        else if (!pdn_n || timing_reset_bit_n == internal_run)
        begin
            internal_run <= internal_run || !pdn_n;
            reset_edges <= 3'h0;
        end
        else if (frame_tick)
        begin
            reset_edges <= next_reset_edges;
            if (internal_run && next_reset_edges == `DACZ_RESET_ASSERT_EDGES)
            begin
                internal_run <= 1'b0;
                reset_edges <= 3'h0;
            end
            else if (!internal_run
                     && next_reset_edges == `DACZ_RESET_RELEASE_EDGES)
            begin
                internal_run <= 1'b1;
                reset_edges <= 3'h0;
            end
        end
    end

    // converter state outputs; float only while powered down by pin or clocks
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            analog_float <= 1'b1;
            converter_running <= 1'b0;
            output_midsupply <= 1'b0;
            timing_reset_active <= 1'b0;
        end
        else
        begin
            analog_float <= power_state != dacz_pkg::DACZ_PWR_RUN;
            converter_running <= power_state == dacz_pkg::DACZ_PWR_RUN
                && internal_run && converter_power_bit;
            output_midsupply <= power_state == dacz_pkg::DACZ_PWR_RUN
                && !(internal_run && converter_power_bit);
            timing_reset_active <= !internal_run;
        end
    end

    // ---------------- zero detection ----------------
    function automatic logic [ZW-1:0] zero_next(input logic [ZW-1:0] count,
                                                input logic is_zero);
        if (!is_zero)
            zero_next = '0;
        else if (count == ZW'(ZERO_FRAMES))
            zero_next = count;
        else
            zero_next = count + ZW'(1);
    endfunction

    logic [ZW-1:0] left_zero_count;
    logic [ZW-1:0] right_zero_count;

    // counts whole frames of zero data per channel, saturating at the limit
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            left_zero_count <= '0;
            right_zero_count <= '0;
        end
        else if (sample_strobe)
        begin
            left_zero_count <= zero_next(left_zero_count, left_sample_zero);
            right_zero_count <= zero_next(right_zero_count, right_sample_zero);
        end
    end

    logic left_hit;
    logic right_hit;
    logic left_detect;
    logic right_detect;
    logic forced;

    assign left_hit = left_zero_count == ZW'(ZERO_FRAMES);
    assign right_hit = right_zero_count == ZW'(ZERO_FRAMES);
    // the written bit forces at once; release waits for the internal timing
    assign forced = !timing_reset_bit_n || !internal_run;
    assign left_detect = forced || (zero_detect_combine_mode
        ? (left_hit && right_hit) : left_hit);
    assign right_detect = forced || (zero_detect_combine_mode
        ? (left_hit && right_hit) : right_hit);

    // pins: power-down and disable win over everything, then polarity
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            left_zero_flag <= 1'b0;
            right_zero_flag <= 1'b0;
        end
        else if (!pdn_n || !zero_detect_enable)
        begin
            left_zero_flag <= 1'b0;
            right_zero_flag <= 1'b0;
        end
        else
        begin
            left_zero_flag <= left_detect ^ zero_flag_polarity;
            right_zero_flag <= right_detect ^ zero_flag_polarity;
        end
    end

    // ---------------- soft mute and volume ramps ----------------
    logic ramp_jump;

    // while stopped by pin, clocks or timing reset there is no audio to click, so the level just jumps
    assign ramp_jump = power_state != dacz_pkg::DACZ_PWR_RUN || !internal_run;

    dacz_ramp left_ramp
    (
        .clock(clock),
        .rst_n(rst_n),
        .frame_tick(frame_tick),
        .jump(ramp_jump),
        .step_frames(step_frames),
        .target(soft_mute_bit ? 8'h00 : left_volume),
        .level(left_gain)
    );

    dacz_ramp right_ramp
    (
        .clock(clock),
        .rst_n(rst_n),
        .frame_tick(frame_tick),
        .jump(ramp_jump),
        .step_frames(step_frames),
        .target(soft_mute_bit ? 8'h00 : right_volume),
        .level(right_gain)
    );
endmodule
`default_nettype wire

// File: bench/dacz_host.sv
`timescale 1ns/1ps
`default_nettype none
module dacz_host
(
    output logic control_clock,
    output logic control_select_n,
    output logic control_data_in
);
    // idle: deselected, link clock parked low
    initial
    begin
        control_clock = 1'h0;
        control_select_n = 1'h1;
        control_data_in = 1'h0;
    end

    // one write frame; the link clock only runs inside it (160 ns period)
    task automatic send(input logic [15:0] word);
        #13;
        control_select_n = 1'h0;
        for (int i = 15; i >= 0; i--)
        begin
            control_data_in = word[i];
            #80 control_clock = 1'h1;
            #80 control_clock = 1'h0;
        end
        #80 control_select_n = 1'h1;
        control_data_in = ~control_data_in; // no stale bit once released
        #400;
    endtask
endmodule
`default_nettype wire

// File: bench/dacz_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dacz_control_asserts
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic control_select_n,
    input wire logic power_down_pin_n,
    input wire logic left_zero_flag,
    input wire logic right_zero_flag,
    input wire logic analog_float,
    input wire logic converter_running,
    input wire logic output_midsupply,
    input wire logic [2:0] audio_format_select,
    input wire logic [1:0] deemphasis_select,
    input wire logic left_output_invert,
    input wire logic [7:0] left_gain
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // pin low long enough to pass the synchronizer
    sequence s_pdn_held;
        !power_down_pin_n [*6];
    endsequence
    // gain moved while the converter kept running
    sequence s_gain_moved;
        converter_running && $past(converter_running) && $changed(left_gain);
    endsequence

    chk_pdn_flags: assert property (s_pdn_held |->
        !left_zero_flag && !right_zero_flag) else $error("flag high in pdn");
    chk_pdn_float: assert property (s_pdn_held |=> analog_float)
        else $error("outputs driven in power-down");
    chk_pdn_defaults: assert property (s_pdn_held |->
        audio_format_select == 3'h2 && deemphasis_select == 2'h1)
        else $error("fields not at default in power-down");
    chk_float_excl: assert property (analog_float |->
        !converter_running && !output_midsupply) else $error("float clash");
    chk_run_excl: assert property (converter_running |->
        !output_midsupply) else $error("running and midsupply together");
    chk_gain_step: assert property (s_gain_moved |->
        left_gain == $past(left_gain) + 8'h01 ||
        left_gain == $past(left_gain) - 8'h01) else $error("gain jumped");
    chk_gain_spacing: assert property (s_gain_moved |=>
        (!converter_running || $stable(left_gain)) [*3])
        else $error("gain steps too close");
    chk_field_commit: assert property ($changed(left_output_invert) &&
        power_down_pin_n && $past(power_down_pin_n, 8) |->
        control_select_n && $past(control_select_n, 3))
        else $error("field changed before chip select rose");
endmodule
bind dacz_control dacz_control_asserts u_chk (.*);
`default_nettype wire

// File: bench/dacz_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dacz_control_bench;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic power_down_pin_n = 1'h0;
    logic master_clock_present = 1'h1;
    logic parallel_select = 1'h0;
    logic [1:0] detected_speed = 2'h0;
    logic frame_clock = 1'h0;
    logic sample_strobe = 1'h0;
    logic left_sample_zero = 1'h0;
    logic right_sample_zero = 1'h0;
    logic control_clock, control_select_n, control_data_in;
    logic left_zero_flag, right_zero_flag, analog_float, converter_running;
    logic output_midsupply, timing_reset_active, slow_rolloff;
    logic left_output_invert, right_output_invert;
    logic [1:0] speed_mode, deemphasis_select;
    logic [2:0] audio_format_select;
    logic [7:0] left_gain, right_gain;
    int miscompares = 0;
    int checks = 0;
    int phase = 0;

    always #25 clock = ~clock;
    // frames of 16 clocks, one sample strobe each
    always @(negedge clock)
    begin
        phase <= (phase + 1) % 16;
        frame_clock <= (phase < 8);
        sample_strobe <= (phase == 3);
    end

    // short zero count keeps the run brief
    dacz_control #(.ZERO_FRAMES(16)) u_dut (.*);
    dacz_host u_host (.*);

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic frames(input int n);
        repeat (n * 16) @(negedge clock);
    endtask

    // a write lands a few clocks after chip select rises
    task automatic wr(input logic [4:0] addr, input logic [7:0] data);
        u_host.send({2'h1, 1'h1, addr, data});
        repeat (8) @(negedge clock);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic t_power_up;
        int n;
        power_down_pin_n <= 1'h1;
        for (n = 0; n < 400 && converter_running !== 1'h1; n++)
            @(negedge clock);
        if (n == 400)
        begin
            miscompares++;
            tally_and_finish();
        end
        chk(8'(audio_format_select), 8'h02);
        chk(8'(deemphasis_select), 8'h01);
        chk(left_gain, 8'hFF);
        chk(right_gain, 8'hFF);
        chk(8'(speed_mode), 8'h00);
    endtask

    task automatic t_fields;
        u_host.send({2'h2, 1'h1, 5'h02, 8'h18});
        repeat (8) @(negedge clock);
        chk(8'(left_output_invert), 8'h00);
        wr(5'h02, 8'h18);
        chk(8'({left_output_invert, right_output_invert}), 8'h03);
        wr(5'h00, 8'h0B);
        wr(5'h01, 8'hAA);
        chk(8'(speed_mode), 8'h01);
        chk(8'(slow_rolloff), 8'h01);
        wr(5'h00, 8'h8B);
        chk(8'(speed_mode), 8'h00);
        // auto setting must follow the detector, quad included
        detected_speed <= 2'h2;
        repeat (2) @(negedge clock);
        chk(8'(speed_mode), 8'h02);
        detected_speed <= 2'h0;
    endtask

    task automatic t_zero;
        left_sample_zero <= 1'h1;
        frames(18);
        chk(8'({left_zero_flag, right_zero_flag}), 8'h02);
        wr(5'h02, 8'h1C);
        chk(8'({left_zero_flag, right_zero_flag}), 8'h01);
        wr(5'h01, 8'hCA);
        chk(8'({left_zero_flag, right_zero_flag}), 8'h03);
        wr(5'h01, 8'h4A);
        chk(8'({left_zero_flag, right_zero_flag}), 8'h00);
        wr(5'h01, 8'hCA);
        right_sample_zero <= 1'h1;
        frames(18);
        chk(8'({left_zero_flag, right_zero_flag}), 8'h00);
        left_sample_zero <= 1'h0;
        right_sample_zero <= 1'h0;
        frames(2);
        chk(8'({left_zero_flag, right_zero_flag}), 8'h03);
        wr(5'h02, 8'h00);
        wr(5'h01, 8'h8A);
    endtask

    task automatic t_reset_mute;
        wr(5'h00, 8'h8A);
        frames(5);
        chk(8'({left_zero_flag, right_zero_flag, output_midsupply}), 8'h07);
        chk(8'(timing_reset_active), 8'h01);
        wr(5'h03, 8'h05);
        wr(5'h00, 8'h8B);
        frames(4);
        chk(8'({left_zero_flag, right_zero_flag, converter_running}), 8'h01);
        chk(left_gain, 8'h05);
        chk(8'(timing_reset_active), 8'h00);
        wr(5'h01, 8'h8B);
        frames(22);
        chk(left_gain, 8'h00);
        wr(5'h01, 8'h8A);
        frames(22);
        chk(left_gain, 8'h05);
        wr(5'h01, 8'h8B);
        frames(9);
        chk(8'(left_gain > 8'h00 && left_gain < 8'h05), 8'h01);
        wr(5'h01, 8'h8A);
        frames(14);
        chk(left_gain, 8'h05);
    endtask

    task automatic t_power_down;
        wr(5'h02, 8'h1C);
        power_down_pin_n <= 1'h0;
        frames(1);
        chk(8'({left_output_invert, analog_float, converter_running}), 8'h02);
        chk(8'({left_zero_flag, right_zero_flag}), 8'h00);
        power_down_pin_n <= 1'h1;
        master_clock_present <= 1'h0;
        frames(1);
        wr(5'h02, 8'h1C);
        chk(8'(left_output_invert), 8'h00);
        master_clock_present <= 1'h1;
        // parallel mode: pulse power-down around the change, then no writes
        parallel_select <= 1'h1;
        power_down_pin_n <= 1'h0;
        frames(1);
        power_down_pin_n <= 1'h1;
        frames(1);
        wr(5'h02, 8'h1C);
        chk(8'(left_output_invert), 8'h00);
        parallel_select <= 1'h0;
    endtask

    // reset, then each scenario in turn
    initial
    begin
        repeat (5) @(negedge clock);
        rst_n <= 1'h1;
        t_power_up();
        t_fields();
        t_zero();
        t_reset_mute();
        t_power_down();
        tally_and_finish();
    end
endmodule
`default_nettype wire
